// File: hdl/hcsip_pkg.sv
// Package with register map, field layout and reset values of the host status and pending bank.
// ==================================================================
`default_nettype none
package hcsip_pkg;
  // ==================================================================
  // Register offsets on the host port.
  localparam logic [7:0] HCSIP_OFS_RDATA_H = 8'h28;
  localparam logic [7:0] HCSIP_OFS_RDATA_L = 8'h2A;
  localparam logic [7:0] HCSIP_OFS_STATUS = 8'h2C;
  localparam logic [7:0] HCSIP_OFS_PEND = 8'h2E;
  localparam logic [7:0] HCSIP_OFS_EN_SET = 8'h30;
  localparam logic [7:0] HCSIP_OFS_EN_CLR = 8'h32;
  localparam logic [7:0] HCSIP_OFS_ACCESS = 8'h34;
  localparam logic [7:0] HCSIP_OFS_STS_CLR = 8'h36;
  // ==================================================================
  // Status register field positions.
  localparam int HCSIP_ST_DONE = 0;
  localparam int HCSIP_ST_ERR = 1;
  localparam int HCSIP_ST_LEN_LO = 4;
  localparam int HCSIP_ST_ID_LO = 8;
  // Pending register bit positions.
  localparam int HCSIP_PEND_ACCESS = 0;
  localparam int HCSIP_PEND_MAILBOX = 6;
  localparam logic [15:0] HCSIP_PEND_MASK = 16'h0041;
  // Access command word: bit 15 read, length code, block select.
  localparam int HCSIP_CMD_READ = 15;
  localparam int HCSIP_CMD_LEN_LO = 4;
  localparam int HCSIP_CMD_ID_LO = 8;
  localparam logic [2:0] HCSIP_WRITE_LEN = 3'h1;
  localparam logic [15:0] HCSIP_RESET_WORD = 16'h0000;
  localparam logic [31:0] HCSIP_RESET_DWORD = 32'h0000_0000;
endpackage
`default_nettype wire

// File: hdl/hcsip_if.sv
// Interface joining the status bank to its host.
`timescale 1ns/100ps
`default_nettype none
interface hcsip_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic irq;
  modport device (input addr, wdata, wr, rd, output rdata, irq);
  modport host (output addr, wdata, wr, rd, input rdata, irq);
endinterface
`default_nettype wire

// File: hdl/hcsip_device.sv
// Device end: indirect access status, read result and peripheral pending registers.
`timescale 1ns/100ps
`default_nettype none
module hcsip_device
  import hcsip_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  hcsip_if.device bus, // Host register port.
  output logic access_start, // Pulse: new indirect access.
  output logic [15:0] access_cmd, // Command word of that access.
  input wire logic access_done, // Pulse: access engine finished.
  input wire logic [31:0] indirect_read_result, // Result or write status.
  input wire logic [3:0] responder_block_id, // Block that answered.
  input wire logic access_error_flag, // Access failed.
  input wire logic mailbox_irq // Mailbox module interrupt pulse.
);
  typedef struct packed {
    logic [31:0] result;
    logic [15:0] status;
    logic [15:0] pend;
    logic [15:0] enable;
    logic [15:0] cmd;
    logic start;
    logic [15:0] rdata;
  } hcsip_dev_s;
  hcsip_dev_s st_reg, st_next;

  // Next-state logic for all registers.
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.rdata = HCSIP_RESET_WORD;
    if (bus.rd) begin
      if (bus.addr == HCSIP_OFS_RDATA_H) begin
        st_next.rdata = st_reg.result[31:16];
      end else if (bus.addr == HCSIP_OFS_RDATA_L) begin
        st_next.rdata = st_reg.result[15:0];
      end else if (bus.addr == HCSIP_OFS_STATUS) begin
        st_next.rdata = st_reg.status;
      end else if (bus.addr == HCSIP_OFS_PEND) begin
        st_next.rdata = st_reg.pend;
      end else if (bus.addr == HCSIP_OFS_EN_SET) begin
        st_next.rdata = st_reg.enable;
      end else if (bus.addr == HCSIP_OFS_ACCESS) begin
        st_next.rdata = st_reg.cmd;
      end
    end
    if (bus.wr) begin
      if (bus.addr == HCSIP_OFS_PEND) begin
        st_next.pend = st_reg.pend & ~bus.wdata;
      end else if (bus.addr == HCSIP_OFS_EN_SET) begin
        st_next.enable = st_reg.enable | (bus.wdata & HCSIP_PEND_MASK);
      end else if (bus.addr == HCSIP_OFS_EN_CLR) begin
        st_next.enable = st_reg.enable & ~bus.wdata;
      end else if (bus.addr == HCSIP_OFS_STS_CLR) begin
        st_next.status[HCSIP_ST_DONE] = st_reg.status[HCSIP_ST_DONE] & ~bus.wdata[HCSIP_ST_DONE];
      end else if (bus.addr == HCSIP_OFS_ACCESS) begin
        st_next.cmd = bus.wdata;
        st_next.start = 1'b1;
      end
    end
    // Completion stores result and fields together with done, so set wins over clear.
    if (access_done) begin
      st_next.result = indirect_read_result;
      st_next.status = HCSIP_RESET_WORD;
      st_next.status[HCSIP_ST_DONE] = 1'b1;
      st_next.status[HCSIP_ST_ERR] = access_error_flag;
      st_next.status[HCSIP_ST_ID_LO +: 4] = responder_block_id;
      st_next.status[HCSIP_ST_LEN_LO +: 3] = st_reg.cmd[HCSIP_CMD_READ] ?
        st_reg.cmd[HCSIP_CMD_LEN_LO +: 3] : HCSIP_WRITE_LEN;
      st_next.pend[HCSIP_PEND_ACCESS] = 1'b1;
    end
    if (mailbox_irq) begin
      st_next.pend[HCSIP_PEND_MAILBOX] = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs.
  assign bus.rdata = st_reg.rdata;
  assign bus.irq = |(st_reg.pend & st_reg.enable);
  assign access_start = st_reg.start;
  assign access_cmd = st_reg.cmd;
endmodule // hcsip_device
`default_nettype wire

// File: hdl/hcsip_host.sv
// Host end: runs one indirect access, polls for done and checks the answer.
`timescale 1ns/100ps
`default_nettype none
module hcsip_host
  import hcsip_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  hcsip_if.host bus, // Device register port.
  input wire logic go, // Pulse: start an access.
  input wire logic [15:0] go_cmd, // Command word.
  output logic busy, // Access in progress.
  output logic finished, // Pulse: access checked.
  output logic fault, // Last access faulty.
  output logic [31:0] result, // Last read result.
  output logic mailbox_seen // Pulse: mailbox pending cleared.
);
  typedef enum logic [6:0] {
    HS_IDLE = 7'b0000001, HS_CLR = 7'b0000010, HS_CMD = 7'b0000100,
    HS_POLL = 7'b0001000, HS_RDH = 7'b0010000, HS_RDL = 7'b0100000,
    HS_MBX = 7'b1000000
  } hcsip_hs_e;
  typedef struct packed {
    hcsip_hs_e state;
    logic [15:0] cmd;
    logic [31:0] result;
    logic fault;
    logic finished;
    logic mbx;
    logic armed;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hcsip_host_s;
  hcsip_host_s st_reg, st_next;

  // Sequencer: clear done, issue, poll and check status, read result.
  always_comb begin
    st_next = st_reg;
    st_next.wr = 1'b0;
    st_next.rd = 1'b0;
    st_next.finished = 1'b0;
    st_next.mbx = 1'b0;
    case (st_reg.state)
      HS_IDLE: begin
        if (go) begin
          st_next.cmd = go_cmd;
          st_next.addr = HCSIP_OFS_STS_CLR;
          st_next.wdata = 16'h0001;
          st_next.wr = 1'b1;
          st_next.state = HS_CLR;
        end else if (!st_reg.armed) begin
          // Enables only the mailbox bit once, so access completions never hold the line high.
          st_next.addr = HCSIP_OFS_EN_SET;
          st_next.wdata = 16'h0040;
          st_next.wr = 1'b1;
          st_next.armed = 1'b1;
        end else if (bus.irq) begin
          st_next.addr = HCSIP_OFS_PEND;
          st_next.wdata = 16'h0040;
          st_next.wr = 1'b1;
          st_next.state = HS_MBX;
        end
      end
      HS_CLR: begin
        st_next.addr = HCSIP_OFS_ACCESS;
        st_next.wdata = st_reg.cmd;
        st_next.wr = 1'b1;
        st_next.state = HS_CMD;
      end
      HS_CMD: begin
        st_next.addr = HCSIP_OFS_STATUS;
        st_next.rd = 1'b1;
        st_next.state = HS_POLL;
      end
      HS_POLL: begin
        // A read answer stands one cycle after its strobe, so wait while a read is in flight.
        if (st_reg.rd) begin
          st_next.state = HS_POLL;
        end else if (bus.rdata[HCSIP_ST_DONE]) begin
          st_next.fault = bus.rdata[HCSIP_ST_ERR] |
            (bus.rdata[HCSIP_ST_LEN_LO +: 3] != (st_reg.cmd[HCSIP_CMD_READ] ?
              st_reg.cmd[HCSIP_CMD_LEN_LO +: 3] : HCSIP_WRITE_LEN)) |
            (bus.rdata[HCSIP_ST_ID_LO +: 4] != st_reg.cmd[HCSIP_CMD_ID_LO +: 4]);
          st_next.addr = HCSIP_OFS_RDATA_H;
          st_next.rd = 1'b1;
          st_next.state = HS_RDH;
        end else begin
          st_next.rd = 1'b1;
        end
      end
      HS_RDH: begin
        if (!st_reg.rd) begin
          st_next.addr = HCSIP_OFS_RDATA_L;
          st_next.rd = 1'b1;
          st_next.result[31:16] = bus.rdata;
          st_next.state = HS_RDL;
        end
      end
      HS_RDL: begin
        if (!st_reg.rd) begin
          st_next.result[15:0] = bus.rdata;
          st_next.finished = 1'b1;
          st_next.state = HS_IDLE;
        end
      end
      HS_MBX: begin
        st_next.mbx = 1'b1;
        st_next.state = HS_IDLE;
      end
      default: begin
        st_next.state = HS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg <= '{state: HS_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; fixed writes keep reserved bits zero, the command word is written as given on go_cmd.
  assign bus.addr = st_reg.addr;
  assign bus.wdata = st_reg.wdata;
  assign bus.wr = st_reg.wr;
  assign bus.rd = st_reg.rd;
  assign busy = (st_reg.state != HS_IDLE);
  assign finished = st_reg.finished;
  assign fault = st_reg.fault;
  assign result = st_reg.result;
  assign mailbox_seen = st_reg.mbx;
endmodule // hcsip_host
`default_nettype wire

// File: tb/hcsip_properties.sv
// Checker of the register port between the host end and the device end.
`timescale 1ns/100ps
`default_nettype none
module hcsip_properties
  import hcsip_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [7:0] addr, // Register offset.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [15:0] rdata, // Read data.
  input wire logic irq, // Interrupt level.
  input wire logic access_start, // Access launch.
  input wire logic access_done, // Access finish.
  input wire logic mailbox_irq // Mailbox event.
);
  // ==================================================================
  // Port timing and field properties.
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("read data outside slot");
  a_start_follows_cmd: assert property (wr && addr == HCSIP_OFS_ACCESS |=> access_start)
    else $error("no launch after command");
  a_start_has_cause: assert property (access_start |-> $past(wr) && $past(addr) == HCSIP_OFS_ACCESS)
    else $error("launch without command");
  a_done_shown: assert property (access_done ##1 (rd && addr == HCSIP_OFS_STATUS) |=> rdata[HCSIP_ST_DONE])
    else $error("done bit missing");
  a_status_rsvd: assert property (rd && addr == HCSIP_OFS_STATUS |=> rdata[15:12] == 4'h0 && rdata[7] == 1'b0)
    else $error("status reserved bits set");
  a_pend_rsvd: assert property (rd && addr == HCSIP_OFS_PEND |=> (rdata & ~HCSIP_PEND_MASK) == 16'h0000)
    else $error("pending reserved bits set");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(access_done || mailbox_irq || wr))
    else $error("interrupt without event");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr))
    else $error("interrupt dropped without write");
endmodule // hcsip_properties
`default_nettype wire

// File: tb/host_csr_status_irq_pending_bench.sv
// Bench joining both ends, plus a second device driven directly for register checks.
`timescale 1ns/100ps
`default_nettype none
module host_csr_status_irq_pending_bench import hcsip_pkg::*;;
  logic clock = 0, reset = 1, go = 0, fault, finished, eng_err = 0, mbx = 0, st_a, st_b;
  logic busy_a, seen_a;
  logic [15:0] go_cmd = 16'h0000, cmd_b;
  logic [31:0] mbx_hits = 32'h0000_0000;
  logic [3:0] eng_id = 4'h0;
  logic [31:0] result, eng_res = 32'h1234_5678;
  logic [2:0] dly_a = 3'h0, dly_b = 3'h0;
  int err_count = 0, n_tests = 0, cyc = 0;
  hcsip_if bus_a ();
  hcsip_if bus_b ();
  always #2.5 clock = ~clock;
  // Access engine stand-in: finishes three cycles after each launch.
  always @(posedge clock) begin
    dly_a <= reset ? 3'h0 : {dly_a[1:0], st_a};
    dly_b <= reset ? 3'h0 : {dly_b[1:0], st_b};
  end
  // Counts mailbox service pulses of the host end.
  always @(posedge clock) begin
    if (seen_a === 1'b1) mbx_hits <= mbx_hits + 32'h0000_0001;
  end
  hcsip_device i_hcsip_device (.clock(clock), .reset(reset), .bus(bus_a.device), .access_start(st_a),
    .access_cmd(), .access_done(dly_a[2]), .indirect_read_result(eng_res), .responder_block_id(eng_id),
    .access_error_flag(eng_err), .mailbox_irq(mbx));
  hcsip_device i_hcsip_device_b (.clock(clock), .reset(reset), .bus(bus_b.device), .access_start(st_b),
    .access_cmd(cmd_b), .access_done(dly_b[2]), .indirect_read_result(eng_res), .responder_block_id(eng_id),
    .access_error_flag(eng_err), .mailbox_irq(mbx));
  hcsip_host i_hcsip_host (.clock(clock), .reset(reset), .bus(bus_a.host), .go(go), .go_cmd(go_cmd),
    .busy(busy_a), .finished(finished), .fault(fault), .result(result), .mailbox_seen(seen_a));
  hcsip_properties i_hcsip_properties (.clock(clock), .reset(reset), .addr(bus_a.addr), .wdata(bus_a.wdata),
    .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata), .irq(bus_a.irq), .access_start(st_a),
    .access_done(dly_a[2]), .mailbox_irq(mbx));
  // ==================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_b.addr <= a;
    bus_b.wdata <= d;
    bus_b.wr <= 1'b1;
    @(posedge clock);
    bus_b.wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    bus_b.addr <= a;
    bus_b.rd <= 1'b1;
    @(posedge clock);
    bus_b.rd <= 1'b0;
    #1 chk({16'h0000, bus_b.rdata}, {16'h0000, e});
  endtask
  task automatic host_run(input logic [15:0] c, input logic [3:0] id, input logic e, input logic f);
    @(posedge clock);
    eng_id <= id;
    eng_err <= e;
    go_cmd <= c;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1 chk({31'h0, busy_a}, 32'h0000_0001);
    for (int k = 0; k < 100; k++) begin
      @(posedge clock);
      #1;
      if (finished === 1'b1) break;
    end
    chk({31'h0, finished}, 32'h0000_0001);
    chk({31'h0, fault}, {31'h0, f});
  endtask
  // ==================================================================
  // Scenarios.
  task automatic t_host;
    host_run(16'h8530, 4'h5, 1'b0, 1'b0);
    chk(result, 32'h1234_5678);
    host_run(16'h8530, 4'h6, 1'b0, 1'b1);
    host_run(16'h0570, 4'h5, 1'b0, 1'b0);
    host_run(16'h0570, 4'h5, 1'b1, 1'b1);
  endtask
  task automatic t_regs;
    rdc(HCSIP_OFS_STATUS, 16'h0000);
    rdc(8'h00, 16'h0000);
    @(posedge clock);
    eng_id <= 4'h3;
    eng_err <= 1'b1;
    eng_res <= 32'hCAFE_0001;
    wr(HCSIP_OFS_ACCESS, 16'h8320);
    chk({16'h0000, cmd_b}, 32'h0000_8320);
    repeat (6) @(posedge clock);
    rdc(HCSIP_OFS_STATUS, 16'h0323);
    rdc(HCSIP_OFS_RDATA_H, 16'hCAFE);
    rdc(HCSIP_OFS_RDATA_L, 16'h0001);
    wr(HCSIP_OFS_STATUS, 16'h0000);
    rdc(HCSIP_OFS_STATUS, 16'h0323);
    @(posedge clock);
    eng_id <= 4'h2;
    eng_err <= 1'b0;
    wr(HCSIP_OFS_ACCESS, 16'h0200);
    repeat (6) @(posedge clock);
    rdc(HCSIP_OFS_STATUS, 16'h0211);
    wr(HCSIP_OFS_STS_CLR, 16'h0001);
    rdc(HCSIP_OFS_STATUS, 16'h0210);
  endtask
  task automatic t_pend;
    rdc(HCSIP_OFS_PEND, 16'h0001);
    chk({31'h0, bus_b.irq}, 32'h0000_0000);
    wr(HCSIP_OFS_EN_SET, 16'h0041);
    chk({31'h0, bus_b.irq}, 32'h0000_0001);
    @(posedge clock);
    mbx <= 1'b1;
    @(posedge clock);
    mbx <= 1'b0;
    rdc(HCSIP_OFS_PEND, 16'h0041);
    wr(HCSIP_OFS_PEND, 16'h0001);
    wr(HCSIP_OFS_PEND, 16'h0000);
    chk(mbx_hits, 32'h0000_0001);
    rdc(HCSIP_OFS_PEND, 16'h0040);
    wr(HCSIP_OFS_EN_CLR, 16'h0040);
    chk({31'h0, bus_b.irq}, 32'h0000_0000);
    wr(HCSIP_OFS_PEND, 16'h0040);
    rdc(HCSIP_OFS_PEND, 16'h0000);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Comparisons %0d, errors %0d.", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence.
  initial begin
    bus_b.addr = 8'h00;
    bus_b.wdata = 16'h0000;
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_host();
    t_regs();
    t_pend();
    results();
  end
  // Hang guard.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
endmodule // host_csr_status_irq_pending_bench
`default_nettype wire
